/* File: pma_map.svh */
`ifndef PMA_MAP_SVH
`define PMA_MAP_SVH

// program address space, 12-bit program counter
`define PMA_PC_W          12
`define PMA_RESET_VEC     12'h000
`define PMA_RSV_FIRST     12'h004
`define PMA_RSV_LAST      12'h007
`define PMA_IRQ_VEC       12'h008
`define PMA_USER_FIRST    12'h010
`define PMA_USER_LAST     12'hFFE
`define PMA_ROM_WORDS     4096
`define PMA_PAGE_WORDS    256

// data address space
`define PMA_SYS_BASE      8'h80
`define PMA_ADDR_RESULT   8'h82
`define PMA_ADDR_PTR_LO   8'h83
`define PMA_ADDR_PTR_MID  8'h84
`define PMA_ADDR_PTR_HI   8'h85
`define PMA_ADDR_BANKSEL  8'h87
`define PMA_BANK_BIT      0
`define PMA_BANKSEL_RST   8'h00
`define PMA_PTR_RST       8'h00
`define PMA_UNDEF_READ    8'hFF
`define PMA_GP_FULL       128
`define PMA_GP_SMALL      48

`endif

/* File: pma_pkg.sv */
`default_nettype none

package pma_pkg;

  // program counter update chosen in a cycle
  typedef enum logic [2:0] {
    PC_HOLD = 3'b000,
    PC_STEP = 3'b001,
    PC_LOAD = 3'b010,
    PC_ADDL = 3'b011,
    PC_PCH  = 3'b100,
    PC_IRQ  = 3'b101
  } pma_pc_op_t;

  // region hit by a data address
  typedef enum logic [1:0] {
    RG_GP0    = 2'b00,
    RG_GP1    = 2'b01,
    RG_SYS    = 2'b10,
    RG_UNUSED = 2'b11
  } pma_region_t;

endpackage : pma_pkg

`default_nettype wire

/* File: pma_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none

// simple word port: requester drives address and write, memory returns data
interface pma_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic [AW-1:0] addr;   // word address
  logic          we;     // write strobe
  logic [DW-1:0] wdata;  // write data
  logic [DW-1:0] rdata;  // read data at addr

  modport req (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : pma_mem_if

`default_nettype wire

/* File: pma_prog_rom.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pma_map.svh"

module pma_prog_rom #(
  parameter int WORDS = `PMA_ROM_WORDS
) (
  // clock
  input  wire logic        sys_clk,
  // table and load port
  pma_mem_if.mem           tbl,
  // instruction fetch port
  input  wire logic [11:0] fetch_addr,
  output logic      [15:0] fetch_data
);
  // opcodes and table words share one array
  logic [15:0] words [WORDS];

  // load from the programming side
  always_ff @(posedge sys_clk) begin
    if (tbl.we) begin
      words[tbl.addr] <= tbl.wdata;
    end
  end

  // both ports read combinationally
  assign tbl.rdata  = words[tbl.addr];
  assign fetch_data = words[fetch_addr];
endmodule : pma_prog_rom

`default_nettype wire

/* File: pma_data_ram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pma_map.svh"

module pma_data_ram #(
  parameter int GP0_SIZE  = `PMA_GP_FULL,
  parameter bit HAS_BANK1 = 1'b1
) (
  // clock
  input  wire logic sys_clk,
  // addr[7] picks the bank, addr[6:0] the byte
  pma_mem_if.mem    port
);
  logic [7:0] gp0 [GP0_SIZE];   // bank zero storage
  logic [7:0] gp1 [128];        // bank one storage

  // writes only land inside the populated area
  always_ff @(posedge sys_clk) begin
    if (port.we && !port.addr[7] && (32'(port.addr[6:0]) < GP0_SIZE)) begin
      gp0[port.addr[6:0]] <= port.wdata;
    end
    if (port.we && port.addr[7] && HAS_BANK1) begin
      gp1[port.addr[6:0]] <= port.wdata;
    end
  end

  // absent bytes read as all ones
  always_comb begin
    port.rdata = `PMA_UNDEF_READ;
    if (!port.addr[7] && (32'(port.addr[6:0]) < GP0_SIZE)) begin
      port.rdata = gp0[port.addr[6:0]];
    end else if (port.addr[7] && HAS_BANK1) begin
      port.rdata = gp1[port.addr[6:0]];
    end
  end
endmodule : pma_data_ram

`default_nettype wire

/* File: pma_core_addr.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pma_map.svh"

module pma_core_addr
  import pma_pkg::*;
#(
  parameter int GP0_SIZE  = `PMA_GP_FULL,
  parameter bit HAS_BANK1 = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wdt_rst,
  // program counter control
  input  wire logic        pc_step,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_addr,
  input  wire logic        pcl_add,
  input  wire logic [7:0]  work_register,
  input  wire logic        pch_wr,
  input  wire logic [7:0]  pch_wdata,
  input  wire logic        irq_take,
  // instruction fetch and stack
  output logic [11:0]      pc,
  output logic [15:0]      fetch_word,
  output logic             stack_push,
  output logic [11:0]      stack_data,
  // table read
  input  wire logic        table_read_instruction,
  output logic             work_load,
  output logic [7:0]       work_load_data,
  // program loading
  input  wire logic        prog_we,
  input  wire logic [11:0] prog_addr,
  input  wire logic [15:0] prog_wdata,
  // data memory access
  input  wire logic [7:0]  dm_addr,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  input  wire logic        dm_bank0,
  input  wire logic [7:0]  dm_wdata,
  output logic [7:0]       dm_rdata,
  output logic             dm_rvalid,
  // bank state
  output logic             bank_select_bit
);
  logic [7:0]  result_reg;           // table high byte, also writable
  logic [7:0]  ptr_lo;               // low table pointer
  logic [7:0]  ptr_mid;              // middle table pointer
  logic [7:0]  ptr_hi;               // highest table pointer
  logic [7:0]  data_bank_select_reg; // bank select register
  logic        tbl_pend;             // table word arrives this cycle
  pma_pc_op_t  pc_op;                // chosen counter update
  pma_region_t wr_rg;                // region of a write
  pma_region_t rd_rg;                // region of a read
  logic        sys_reset;            // either reset source
  logic [15:0] rom_fetch;            // word at the counter
  logic [7:0]  sys_rdata;            // system register read mux

  pma_mem_if #(.AW(12), .DW(16)) rom_if ();
  pma_mem_if #(.AW(8),  .DW(8))  ram_if ();

  assign sys_reset       = !rst_n || wdt_rst;
  assign bank_select_bit = data_bank_select_reg[`PMA_BANK_BIT];

  // classify a data address under the current bank
  function automatic pma_region_t region_of(input logic [7:0] a, input logic b0, input logic bank);
    if (b0 || !bank) begin
      region_of = a[7] ? RG_SYS : RG_GP0;
    end else begin
      region_of = a[7] ? RG_UNUSED : RG_GP1;
    end
  endfunction : region_of

  assign wr_rg = region_of(dm_addr, dm_bank0, bank_select_bit);
  assign rd_rg = region_of(dm_addr, dm_bank0, bank_select_bit);

  // program memory, table and load share one port
  assign rom_if.addr  = prog_we ? prog_addr : {ptr_mid[3:0], ptr_lo};
  assign rom_if.we    = prog_we;
  assign rom_if.wdata = prog_wdata;

  pma_prog_rom #(.WORDS(`PMA_ROM_WORDS)) u_rom (
    .sys_clk    (sys_clk),
    .tbl        (rom_if),
    .fetch_addr (pc),
    .fetch_data (rom_fetch)
  );

  // general storage, bank in addr[7]
  assign ram_if.addr  = {(wr_rg == RG_GP1), dm_addr[6:0]};
  assign ram_if.we    = dm_wr && (wr_rg == RG_GP0 || wr_rg == RG_GP1);
  assign ram_if.wdata = dm_wdata;

  pma_data_ram #(.GP0_SIZE(GP0_SIZE), .HAS_BANK1(HAS_BANK1)) u_ram (
    .sys_clk (sys_clk),
    .port    (ram_if)
  );

  // pick the counter update, interrupt first
  always_comb begin
    if (irq_take) begin
      pc_op = PC_IRQ;
    end else if (pc_load) begin
      pc_op = PC_LOAD;
    end else if (pcl_add) begin
      pc_op = PC_ADDL;
    end else if (pch_wr) begin
      pc_op = PC_PCH;
    end else if (pc_step) begin
      pc_op = PC_STEP;
    end else begin
      pc_op = PC_HOLD;
    end
  end

  // program counter
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      pc <= `PMA_RESET_VEC;
    end else begin
      unique case (pc_op)
        PC_HOLD: pc <= pc;
        PC_STEP: pc <= pc + 12'h001;
        PC_LOAD: pc <= pc_load_addr;
        PC_ADDL: pc <= {pc[11:8], pc[7:0] + work_register};
        PC_PCH:  pc <= {pch_wdata[3:0], pc[7:0]};
        PC_IRQ:  pc <= `PMA_IRQ_VEC;
        default: pc <= `PMA_RESET_VEC;
      endcase
    end
  end

  // return address goes to the stack on interrupt entry
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      stack_push <= 1'b0;
      stack_data <= `PMA_RESET_VEC;
    end else begin
      stack_push <= irq_take;
      if (irq_take) begin
        stack_data <= pc;
      end
    end
  end

  // instruction word at the counter, one cycle behind
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      fetch_word <= 16'h0000;
    end else begin
      fetch_word <= rom_fetch;
    end
  end

  // table read: one cycle from request to result
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      tbl_pend       <= 1'b0;
      work_load      <= 1'b0;
      work_load_data <= 8'h00;
    end else begin
      tbl_pend  <= table_read_instruction && !prog_we;
      work_load <= 1'b0;
      if (table_read_instruction && !prog_we) begin
        work_load      <= 1'b1;
        work_load_data <= rom_if.rdata[7:0];
      end
    end
  end

  // result register, table result beats a software write
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      result_reg <= `PMA_PTR_RST;
    end else if (table_read_instruction && !prog_we) begin
      result_reg <= rom_if.rdata[15:8];
    end else if (dm_wr && wr_rg == RG_SYS && dm_addr == `PMA_ADDR_RESULT) begin
      result_reg <= dm_wdata;
    end
  end

  // table pointers, each written alone with no carry between them
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      ptr_lo  <= `PMA_PTR_RST;
      ptr_mid <= `PMA_PTR_RST;
      ptr_hi  <= `PMA_PTR_RST;
    end else if (dm_wr && wr_rg == RG_SYS) begin
      if (dm_addr == `PMA_ADDR_PTR_LO)  ptr_lo  <= dm_wdata;
      if (dm_addr == `PMA_ADDR_PTR_MID) ptr_mid <= dm_wdata;
      if (dm_addr == `PMA_ADDR_PTR_HI)  ptr_hi  <= dm_wdata;
    end
  end

  // bank select register, only bit 0 is stored
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      data_bank_select_reg <= `PMA_BANKSEL_RST;
    end else if (dm_wr && wr_rg == RG_SYS && dm_addr == `PMA_ADDR_BANKSEL) begin
      data_bank_select_reg <= {7'h00, dm_wdata[`PMA_BANK_BIT]};
    end
  end

  // system area read mux
  always_comb begin
    unique case (dm_addr)
      `PMA_ADDR_RESULT:  sys_rdata = result_reg;
      `PMA_ADDR_PTR_LO:  sys_rdata = ptr_lo;
      `PMA_ADDR_PTR_MID: sys_rdata = ptr_mid;
      `PMA_ADDR_PTR_HI:  sys_rdata = ptr_hi;
      `PMA_ADDR_BANKSEL: sys_rdata = data_bank_select_reg;
      default:           sys_rdata = `PMA_UNDEF_READ;
    endcase
  end

  // registered data read, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (sys_reset) begin
      dm_rdata  <= 8'h00;
      dm_rvalid <= 1'b0;
    end else begin
      dm_rvalid <= dm_rd;
      if (dm_rd) begin
        unique case (rd_rg)
          RG_SYS:    dm_rdata <= sys_rdata;
          RG_UNUSED: dm_rdata <= `PMA_UNDEF_READ;
          RG_GP0:    dm_rdata <= ram_if.rdata;
          RG_GP1:    dm_rdata <= ram_if.rdata;
        endcase
      end
    end
  end

  // checks
  reset_vector_a: assert property (@(posedge sys_clk)
    wdt_rst |=> pc == `PMA_RESET_VEC)
    else $error("counter not at zero after watchdog reset");

  irq_vector_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    irq_take |=> pc == `PMA_IRQ_VEC)
    else $error("interrupt did not reach the vector");

  stack_save_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    irq_take |=> stack_push && stack_data == $past(pc))
    else $error("return address not pushed");

  page_keep_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (pc_op == PC_ADDL) |=> pc[11:8] == $past(pc[11:8])
      && pc[7:0] == 8'($past(pc[7:0]) + $past(work_register)))
    else $error("computed jump left its page");

  table_split_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (table_read_instruction && !prog_we) |=> work_load
      && {result_reg, work_load_data} == $past(rom_if.rdata))
    else $error("table word halves misplaced");

  table_addr_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    !prog_we |-> rom_if.addr == {ptr_mid[3:0], ptr_lo})
    else $error("table address not built from pointers");

  no_carry_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (ptr_lo == 8'hFF && !(dm_wr && dm_addr == `PMA_ADDR_PTR_MID)) |=> $stable(ptr_mid))
    else $error("middle pointer moved on its own");

  bank_reg_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (dm_wr && wr_rg == RG_SYS && dm_addr == `PMA_ADDR_BANKSEL) |=>
      bank_select_bit == $past(dm_wdata[0]) && data_bank_select_reg[7:1] == 7'h00)
    else $error("bank select write lost");

  undef_read_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (dm_rd && rd_rg == RG_SYS && (dm_addr < `PMA_ADDR_RESULT || dm_addr == 8'h86 || dm_addr > `PMA_ADDR_BANKSEL))
      |=> dm_rdata == `PMA_UNDEF_READ)
    else $error("undefined system location not all ones");

  bank_steer_a: assert property (@(posedge sys_clk) disable iff (sys_reset)
    (dm_wr && !dm_addr[7]) |-> ram_if.addr[7] == (bank_select_bit && !dm_bank0))
    else $error("write sent to the wrong bank");
endmodule : pma_core_addr

`default_nettype wire

/* File: program_and_data_memory_addressing_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module program_and_data_memory_addressing_tb;
  // clock, resets, program counter and table read controls
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wdt_rst = 1'b0;
  logic        pc_step = 1'b0;
  logic        pc_load = 1'b0;
  logic [11:0] pc_load_addr = 12'h000;
  logic        pcl_add = 1'b0;
  logic [7:0]  work_register = 8'h00;
  logic        pch_wr = 1'b0;
  logic [7:0]  pch_wdata = 8'h00;
  logic        irq_take = 1'b0;
  logic        table_read_instruction = 1'b0;
  // program load and data access
  logic        prog_we = 1'b0;
  logic [11:0] prog_addr = 12'h000;
  logic [15:0] prog_wdata = 16'h0000;
  logic [7:0]  dm_addr = 8'h00;
  logic        dm_rd = 1'b0;
  logic        dm_wr = 1'b0;
  logic        dm_bank0 = 1'b0;
  logic [7:0]  dm_wdata = 8'h00;
  // observed outputs
  logic [11:0] pc;
  logic [15:0] fetch_word;
  logic        stack_push;
  logic [11:0] stack_data;
  logic        work_load;
  logic [7:0]  work_load_data;
  logic [7:0]  dm_rdata;
  logic        dm_rvalid;
  logic        bank_select_bit;
  // result counters
  int          fails = 0;
  int          checks = 0;

  pma_core_addr u_pma_core_addr (
    .sys_clk(sys_clk), .rst_n(rst_n), .wdt_rst(wdt_rst), .pc_step(pc_step),
    .pc_load(pc_load), .pc_load_addr(pc_load_addr), .pcl_add(pcl_add),
    .work_register(work_register), .pch_wr(pch_wr), .pch_wdata(pch_wdata),
    .irq_take(irq_take), .pc(pc), .fetch_word(fetch_word), .stack_push(stack_push),
    .stack_data(stack_data), .table_read_instruction(table_read_instruction),
    .work_load(work_load), .work_load_data(work_load_data), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .dm_addr(dm_addr), .dm_rd(dm_rd),
    .dm_wr(dm_wr), .dm_bank0(dm_bank0), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .dm_rvalid(dm_rvalid), .bank_select_bit(bank_select_bit)
  );

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // one edge, then a fixed small delay before inputs move
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // data write, bank0 forces bank zero
  task automatic dm_write(input logic [7:0] a, input logic [7:0] d, input logic b0);
    dm_addr = a;
    dm_wdata = d;
    dm_bank0 = b0;
    dm_wr = 1'b1;
    tick();
    dm_wr = 1'b0;
    dm_bank0 = 1'b0;
    tick();
  endtask : dm_write

  // data read, answer one cycle after the request
  task automatic dm_read(input logic [7:0] a, input logic b0, input logic [7:0] exp);
    dm_addr = a;
    dm_bank0 = b0;
    dm_rd = 1'b1;
    tick();
    dm_rd = 1'b0;
    dm_bank0 = 1'b0;
    check({15'h0000, dm_rvalid}, 16'h0001);
    check({8'h00, dm_rdata}, {8'h00, exp});
    tick();
  endtask : dm_read

  // direct counter load
  task automatic load_pc(input logic [11:0] a);
    pc_load_addr = a;
    pc_load = 1'b1;
    tick();
    pc_load = 1'b0;
  endtask : load_pc

  // values straight after reset
  task automatic test_reset();
    check({4'h0, pc}, 16'h0000);
    check({15'h0000, bank_select_bit}, 16'h0000);
    dm_read(8'h87, 1'b0, 8'h00);
  endtask : test_reset

  // computed jump drops the carry, upper four counter bits kept
  task automatic test_jump();
    load_pc(12'h3FD);
    work_register = 8'h05;
    pcl_add = 1'b1;
    tick();
    pcl_add = 1'b0;
    check({4'h0, pc}, 16'h0302);
    pch_wdata = 8'h0A;
    pch_wr = 1'b1;
    tick();
    pch_wr = 1'b0;
    check({4'h0, pc}, 16'h0A02);
    load_pc(12'h100);
    work_register = 8'h03;
    pcl_add = 1'b1;
    tick();
    pcl_add = 1'b0;
    check({4'h0, pc}, 16'h0103);
  endtask : test_jump

  // interrupt entry and push of the old counter
  task automatic test_irq();
    load_pc(12'h123);
    irq_take = 1'b1;
    tick();
    irq_take = 1'b0;
    check({4'h0, pc}, 16'h0008);
    check({15'h0000, stack_push}, 16'h0001);
    check({4'h0, stack_data}, 16'h0123);
    tick();
    check({15'h0000, stack_push}, 16'h0000);
  endtask : test_irq

  // table read through the low and middle pointers, split result
  task automatic test_table();
    prog_addr = 12'h3FF;
    prog_wdata = 16'h5105;
    prog_we = 1'b1;
    tick();
    prog_we = 1'b0;
    dm_write(8'h83, 8'hFF, 1'b0);
    dm_write(8'h84, 8'h03, 1'b0);
    dm_write(8'h85, 8'h00, 1'b0);
    table_read_instruction = 1'b1;
    tick();
    table_read_instruction = 1'b0;
    check({15'h0000, work_load}, 16'h0001);
    check({8'h00, work_load_data}, 16'h0005);
    tick();
    check({15'h0000, work_load}, 16'h0000);
    dm_read(8'h82, 1'b0, 8'h51);
    dm_read(8'h84, 1'b0, 8'h03);
    load_pc(12'h3FF);
    tick();
    check(fetch_word, 16'h5105);
  endtask : test_table

  // bank steering and the undefined places
  task automatic test_banks();
    dm_write(8'h10, 8'hAA, 1'b0);
    dm_write(8'h87, 8'h01, 1'b0);
    check({15'h0000, bank_select_bit}, 16'h0001);
    dm_write(8'h10, 8'h55, 1'b0);
    dm_read(8'h10, 1'b0, 8'h55);
    dm_read(8'h10, 1'b1, 8'hAA);
    dm_read(8'h90, 1'b0, 8'hFF);
    dm_read(8'h86, 1'b1, 8'hFF);
    dm_read(8'h87, 1'b1, 8'h01);
  endtask : test_banks

  // watchdog reset acts like the reset pin
  task automatic test_wdt();
    load_pc(12'h456);
    wdt_rst = 1'b1;
    tick();
    wdt_rst = 1'b0;
    check({4'h0, pc}, 16'h0000);
    check({15'h0000, bank_select_bit}, 16'h0000);
    pc_step = 1'b1;
    tick();
    pc_step = 1'b0;
    check({4'h0, pc}, 16'h0001);
  endtask : test_wdt

  // counts and verdict, ends the run
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // guard against a hang
  initial begin
    #200000;
    fails++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    tick();
    test_reset();
    test_jump();
    test_irq();
    test_table();
    test_banks();
    test_wdt();
    summarize();
  end
endmodule : program_and_data_memory_addressing_tb

`default_nettype wire
